// ==== hw/phy_cfg_pkg.sv ====
// Behaviour
// - CRS select in 10 Mbit mode holds CRS until RXDV drops; resets one.
// - Preamble bit clear: RXDV with SFD; set: RXDV and preamble with CRS.
// - 10 Mbit serial bit set: receive data bitwise on RXD bit 0.
// - Far-end-fault sent only while its enable bit is one; resets one.
// - Alternate next-page bit enables that feature; resets zero.
// - Media select bit: one is fiber, zero twisted pair; read and write.
// - Hardware reset loads media select bit from that port's strap pin.
// - Read-only 3-bit cable length, resets 000, invalid during gain hold.
// - Rise time field: 00 3.3 ns, 01 3.6, 10 3.9, 11 4.2 ns.
// - Reset loads rise time field from strap pins; software may overwrite.
// - Crossover bit picks pairs; auto crossover has own bit; both reset one.
// - Analog loopback bit loops via analog path while still driving pair.
// - Loopback detection runs only while its enable bit is set; resets zero.
// - Speed-up bit selects accelerated loopback detection.
// - Read-only status bit shows one while loopback detected; resets zero.
package phy_cfg_pkg;
   localparam logic [4:0] ADDR_PORT_CFG = 5'h10;
   localparam logic [4:0] ADDR_SPECIAL = 5'h1b;
   // Port configuration field positions.
   localparam int POS_CRS_SEL = 7;
   localparam int POS_PRE_EN = 5;
   localparam int POS_SERIAL = 3;
   localparam int POS_FEF_EN = 2;
   localparam int POS_ALT_NP = 1;
   localparam int POS_FIBER = 0;
   // Special function field positions.
   localparam int POS_LINE_LEN = 13;
   localparam int POS_RISE = 10;
   localparam int POS_AUTO_MDIX = 9;
   localparam int POS_MDIX = 8;
   localparam int POS_ANA_LOOP = 7;
   localparam int POS_LD_EN = 6;
   localparam int POS_LD_FAST = 5;
   localparam int POS_LD_FOUND = 4;
   // Reset values.
   localparam logic RST_CRS_SEL = 1'b1;
   localparam logic RST_PRE_EN = 1'b0;
   localparam logic RST_SERIAL = 1'b0;
   localparam logic RST_FEF_EN = 1'b1;
   localparam logic RST_ALT_NP = 1'b0;
   localparam logic RST_AUTO_MDIX = 1'b1;
   localparam logic RST_MDIX = 1'b1;
   localparam logic RST_ANA_LOOP = 1'b0;
   localparam logic RST_LD_EN = 1'b0;
   localparam logic RST_LD_FAST = 1'b0;
   localparam logic [2:0] RST_LINE_LEN = 3'h0;
   localparam logic [1:0] RST_RISE = 2'h0;
   // Transmit rise time for code 00 and step per code, in picoseconds.
   localparam int RISE_BASE_PS = 3300;
   localparam int RISE_STEP_PS = 300;
   typedef enum logic [1:0] {
      ST_SYNC0 = 2'b00,
      ST_SYNC1 = 2'b01,
      ST_LOAD = 2'b10,
      ST_RUN = 2'b11
   } init_state_t;
endpackage

// ==== hw/sync_two.sv ====
`timescale 1ns/10ps
`default_nettype none
module sync_two #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Level crossing.
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] first_reg;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_reg <= '0;
         sync_out <= '0;
      end else begin
         first_reg <= async_in;
         sync_out <= first_reg;
      end
   end
endmodule
`default_nettype wire

// ==== hw/rx_shaper.sv ====
`timescale 1ns/10ps
`default_nettype none
module rx_shaper (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Settings.
   input wire logic crs_sel,
   input wire logic pre_en,
   input wire logic serial_en,
   input wire logic ten_mbps,
   // Receive core.
   input wire logic core_crs,
   input wire logic core_dv,
   input wire logic [3:0] core_rxd,
   input wire logic core_rx_bit,
   // MII receive side.
   output logic mii_crs,
   output logic mii_rx_dv,
   output logic [3:0] mii_rxd
);
   logic dv_next;
   logic crs_next;
   logic [3:0] rxd_next;

   always_comb begin
      dv_next = core_dv | (pre_en & core_crs);
      crs_next = core_crs | (crs_sel & ten_mbps & dv_next);
      if (!dv_next) begin
         rxd_next = 4'h0;
      end else if (serial_en && ten_mbps) begin
         rxd_next = {3'h0, core_rx_bit};
      end else begin
         rxd_next = core_rxd;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mii_crs <= 1'b0;
         mii_rx_dv <= 1'b0;
         mii_rxd <= 4'h0;
      end else begin
         mii_crs <= crs_next;
         mii_rx_dv <= dv_next;
         mii_rxd <= rxd_next;
      end
   end
endmodule
`default_nettype wire

// ==== hw/phy_port_special_config_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module phy_port_special_config_regs #(
   parameter int PORTS = 2
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // Strap pins.
   input wire logic [PORTS-1:0] media_select_strap,
   input wire logic [1:0] rise_time_strap,
   // Management register port.
   input wire logic mgmt_port,
   input wire logic [4:0] mgmt_addr,
   input wire logic mgmt_wr_en,
   input wire logic mgmt_rd_en,
   input wire logic [15:0] mgmt_wdata,
   output logic [15:0] mgmt_rdata,
   output logic mgmt_rvalid,
   output logic mgmt_ready,
   // Port core status.
   input wire logic [PORTS-1:0] ten_mbps,
   input wire logic [PORTS-1:0] gain_hold,
   input wire logic [2:0] line_len_est [PORTS],
   input wire logic [PORTS-1:0] loop_seen,
   input wire logic [PORTS-1:0] auto_pair_swap,
   input wire logic [PORTS-1:0] fef_request,
   // Port core controls.
   output logic [PORTS-1:0] fef_tx,
   output logic [PORTS-1:0] alt_np_en,
   output logic [PORTS-1:0] fiber_mode,
   output logic [1:0] rise_sel [PORTS],
   output logic [15:0] rise_time_ps [PORTS],
   output logic [PORTS-1:0] tx_on_pair_b,
   output logic [PORTS-1:0] analog_loop_en,
   output logic [PORTS-1:0] loop_detect_run,
   output logic [PORTS-1:0] loop_detect_fast,
   // Receive core.
   input wire logic [PORTS-1:0] core_crs,
   input wire logic [PORTS-1:0] core_dv,
   input wire logic [3:0] core_rxd [PORTS],
   input wire logic [PORTS-1:0] core_rx_bit,
   // MII receive side.
   output logic [PORTS-1:0] mii_crs,
   output logic [PORTS-1:0] mii_rx_dv,
   output logic [3:0] mii_rxd [PORTS]
);
   if (PORTS != 2) begin : g_port_check
      $error("PORTS must be 2");
   end

   function automatic logic [15:0] rise_ps(input logic [1:0] code);
      int ps;
      ps = phy_cfg_pkg::RISE_BASE_PS + phy_cfg_pkg::RISE_STEP_PS * int'(code);
      return ps[15:0];
   endfunction

   function automatic logic port_hit(input logic sel, input int idx);
      return sel == idx[0];
   endfunction

   logic rst_meta_reg;
   logic rst_n;
   logic [PORTS-1:0] strap_media_sync;
   logic [1:0] strap_rise_sync;
   phy_cfg_pkg::init_state_t state_reg;

   logic [PORTS-1:0] crs_sel_reg;
   logic [PORTS-1:0] pre_en_reg;
   logic [PORTS-1:0] serial_reg;
   logic [PORTS-1:0] fef_en_reg;
   logic [PORTS-1:0] alt_np_reg;
   logic [PORTS-1:0] fiber_reg;
   logic [1:0] rise_reg [PORTS];
   logic [PORTS-1:0] auto_mdix_reg;
   logic [PORTS-1:0] mdix_reg;
   logic [PORTS-1:0] ana_loop_reg;
   logic [PORTS-1:0] ld_en_reg;
   logic [PORTS-1:0] ld_fast_reg;
   logic [PORTS-1:0] ld_found_reg;
   logic [2:0] line_len_reg [PORTS];
   logic [15:0] rdata_next;

   // Reset is asserted at once and released through two flip-flops.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   sync_two #(.WIDTH(PORTS)) u_sync_media (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(media_select_strap),
      .sync_out(strap_media_sync)
   );

   sync_two #(.WIDTH(2)) u_sync_rise (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(rise_time_strap),
      .sync_out(strap_rise_sync)
   );

   // Straps settle through the synchronisers before they are loaded.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= phy_cfg_pkg::ST_SYNC0;
      end else begin
         case (state_reg)
            phy_cfg_pkg::ST_SYNC0: state_reg <= phy_cfg_pkg::ST_SYNC1;
            phy_cfg_pkg::ST_SYNC1: state_reg <= phy_cfg_pkg::ST_LOAD;
            phy_cfg_pkg::ST_LOAD: state_reg <= phy_cfg_pkg::ST_RUN;
            default: state_reg <= phy_cfg_pkg::ST_RUN;
         endcase
      end
   end

   assign mgmt_ready = (state_reg == phy_cfg_pkg::ST_RUN);

   logic wr_cfg;
   logic wr_spc;
   assign wr_cfg = mgmt_ready && mgmt_wr_en
      && (mgmt_addr == phy_cfg_pkg::ADDR_PORT_CFG);
   assign wr_spc = mgmt_ready && mgmt_wr_en
      && (mgmt_addr == phy_cfg_pkg::ADDR_SPECIAL);

   for (genvar p = 0; p < PORTS; p++) begin : g_port
      logic hit;
      assign hit = port_hit(mgmt_port, p);

      // Port configuration fields.
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            crs_sel_reg[p] <= phy_cfg_pkg::RST_CRS_SEL;
            pre_en_reg[p] <= phy_cfg_pkg::RST_PRE_EN;
            serial_reg[p] <= phy_cfg_pkg::RST_SERIAL;
            fef_en_reg[p] <= phy_cfg_pkg::RST_FEF_EN;
            alt_np_reg[p] <= phy_cfg_pkg::RST_ALT_NP;
            fiber_reg[p] <= 1'b0;
         end else if (state_reg == phy_cfg_pkg::ST_LOAD) begin
            fiber_reg[p] <= strap_media_sync[p];
         end else if (wr_cfg && hit) begin
            crs_sel_reg[p] <= mgmt_wdata[phy_cfg_pkg::POS_CRS_SEL];
            pre_en_reg[p] <= mgmt_wdata[phy_cfg_pkg::POS_PRE_EN];
            serial_reg[p] <= mgmt_wdata[phy_cfg_pkg::POS_SERIAL];
            fef_en_reg[p] <= mgmt_wdata[phy_cfg_pkg::POS_FEF_EN];
            alt_np_reg[p] <= mgmt_wdata[phy_cfg_pkg::POS_ALT_NP];
            fiber_reg[p] <= mgmt_wdata[phy_cfg_pkg::POS_FIBER];
         end
      end

      // Special function fields.
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            rise_reg[p] <= phy_cfg_pkg::RST_RISE;
            auto_mdix_reg[p] <= phy_cfg_pkg::RST_AUTO_MDIX;
            mdix_reg[p] <= phy_cfg_pkg::RST_MDIX;
            ana_loop_reg[p] <= phy_cfg_pkg::RST_ANA_LOOP;
            ld_en_reg[p] <= phy_cfg_pkg::RST_LD_EN;
            ld_fast_reg[p] <= phy_cfg_pkg::RST_LD_FAST;
         end else if (state_reg == phy_cfg_pkg::ST_LOAD) begin
            rise_reg[p] <= strap_rise_sync;
         end else if (wr_spc && hit) begin
            rise_reg[p] <= mgmt_wdata[phy_cfg_pkg::POS_RISE +: 2];
            auto_mdix_reg[p] <= mgmt_wdata[phy_cfg_pkg::POS_AUTO_MDIX];
            mdix_reg[p] <= mgmt_wdata[phy_cfg_pkg::POS_MDIX];
            ana_loop_reg[p] <= mgmt_wdata[phy_cfg_pkg::POS_ANA_LOOP];
            ld_en_reg[p] <= mgmt_wdata[phy_cfg_pkg::POS_LD_EN];
            ld_fast_reg[p] <= mgmt_wdata[phy_cfg_pkg::POS_LD_FAST];
         end
      end

      // Status fields; the cable estimate freezes during gain hold.
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            line_len_reg[p] <= phy_cfg_pkg::RST_LINE_LEN;
            ld_found_reg[p] <= 1'b0;
         end else begin
            if (!gain_hold[p]) begin
               line_len_reg[p] <= line_len_est[p];
            end
            ld_found_reg[p] <= loop_seen[p] & ld_en_reg[p];
         end
      end

      assign fef_tx[p] = fef_request[p] & fef_en_reg[p];
      assign alt_np_en[p] = alt_np_reg[p];
      assign fiber_mode[p] = fiber_reg[p];
      assign rise_sel[p] = rise_reg[p];
      assign rise_time_ps[p] = rise_ps(rise_reg[p]);
      assign tx_on_pair_b[p] = auto_mdix_reg[p] ? auto_pair_swap[p]
         : mdix_reg[p];
      assign analog_loop_en[p] = ana_loop_reg[p];
      assign loop_detect_run[p] = ld_en_reg[p];
      assign loop_detect_fast[p] = ld_en_reg[p] & ld_fast_reg[p];

      rx_shaper u_rx (
         .clk(clk),
         .rst_n(rst_n),
         .crs_sel(crs_sel_reg[p]),
         .pre_en(pre_en_reg[p]),
         .serial_en(serial_reg[p]),
         .ten_mbps(ten_mbps[p]),
         .core_crs(core_crs[p]),
         .core_dv(core_dv[p]),
         .core_rxd(core_rxd[p]),
         .core_rx_bit(core_rx_bit[p]),
         .mii_crs(mii_crs[p]),
         .mii_rx_dv(mii_rx_dv[p]),
         .mii_rxd(mii_rxd[p])
      );
   end

   // Read data; reserved and unmapped bits read as zero.
   always_comb begin
      logic s;
      s = mgmt_port;
      rdata_next = 16'h0000;
      if (mgmt_addr == phy_cfg_pkg::ADDR_PORT_CFG) begin
         rdata_next[phy_cfg_pkg::POS_CRS_SEL] = crs_sel_reg[s];
         rdata_next[phy_cfg_pkg::POS_PRE_EN] = pre_en_reg[s];
         rdata_next[phy_cfg_pkg::POS_SERIAL] = serial_reg[s];
         rdata_next[phy_cfg_pkg::POS_FEF_EN] = fef_en_reg[s];
         rdata_next[phy_cfg_pkg::POS_ALT_NP] = alt_np_reg[s];
         rdata_next[phy_cfg_pkg::POS_FIBER] = fiber_reg[s];
      end else if (mgmt_addr == phy_cfg_pkg::ADDR_SPECIAL) begin
         rdata_next[phy_cfg_pkg::POS_LINE_LEN +: 3] = line_len_reg[s];
         rdata_next[phy_cfg_pkg::POS_RISE +: 2] = rise_reg[s];
         rdata_next[phy_cfg_pkg::POS_AUTO_MDIX] = auto_mdix_reg[s];
         rdata_next[phy_cfg_pkg::POS_MDIX] = mdix_reg[s];
         rdata_next[phy_cfg_pkg::POS_ANA_LOOP] = ana_loop_reg[s];
         rdata_next[phy_cfg_pkg::POS_LD_EN] = ld_en_reg[s];
         rdata_next[phy_cfg_pkg::POS_LD_FAST] = ld_fast_reg[s];
         rdata_next[phy_cfg_pkg::POS_LD_FOUND] = ld_found_reg[s];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mgmt_rdata <= 16'h0000;
         mgmt_rvalid <= 1'b0;
      end else begin
         mgmt_rvalid <= mgmt_rd_en & mgmt_ready;
         if (mgmt_rd_en && mgmt_ready) begin
            mgmt_rdata <= rdata_next;
         end
      end
   end

   // Checks.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_crs_hold: assert property (
      (ten_mbps[0] && crs_sel_reg[0] && mii_rx_dv[0]) |-> mii_crs[0])
      else $error("CRS dropped while RXDV still high");
   a_dv_preamble: assert property (
      (pre_en_reg[0] && core_crs[0]) |=> mii_rx_dv[0])
      else $error("RXDV not raised with carrier in preamble mode");
   a_dv_sfd: assert property (
      (!pre_en_reg[0] && !core_dv[0]) |=> !mii_rx_dv[0])
      else $error("RXDV raised before frame delimiter");
   a_serial_bit: assert property (
      (serial_reg[0] && ten_mbps[0] && core_dv[0])
      |=> mii_rxd[0][3:1] == 3'h0 && mii_rxd[0][0] == $past(core_rx_bit[0]))
      else $error("Serial receive data not on bit 0");
   a_fef_gate: assert property (
      fef_tx[0] |-> fef_en_reg[0] && fef_request[0])
      else $error("Far end fault sent while disabled");
   a_strap_load: assert property (
      state_reg == phy_cfg_pkg::ST_LOAD |=>
      fiber_mode == $past(strap_media_sync)
      && rise_sel[1] == $past(strap_rise_sync))
      else $error("Straps not loaded after reset");
   a_write_isolate: assert property (
      (wr_cfg && mgmt_port) |=>
      $stable(fiber_reg[0]) && $stable(pre_en_reg[0]))
      else $error("Write to port one changed port zero");
   a_read_back: assert property (
      (wr_cfg && !mgmt_port) ##1 (mgmt_rd_en && !mgmt_port
      && mgmt_addr == phy_cfg_pkg::ADDR_PORT_CFG) |=>
      mgmt_rvalid && mgmt_rdata[0] == $past(mgmt_wdata[0], 2))
      else $error("Media select read back wrong");
   a_rise_value: assert property (
      rise_time_ps[1] == 16'(3300 + 300 * int'(rise_sel[1])))
      else $error("Rise time does not match field");
   a_loop_status: assert property (
      (loop_seen[1] && loop_detect_run[1]) |=> ld_found_reg[1])
      else $error("Loopback detect status not set");
   a_line_freeze: assert property (
      gain_hold[0] |=> $stable(line_len_reg[0]))
      else $error("Cable length moved during gain hold");
   a_mdix_manual: assert property (
      !auto_mdix_reg[1] |-> tx_on_pair_b[1] == mdix_reg[1])
      else $error("Manual crossover not honoured");
   a_fef_off: assert property (
      !fef_en_reg[1] |-> !fef_tx[1])
      else $error("Far end fault sent with enable clear");
   a_cfg_write: assert property (
      (wr_cfg && !mgmt_port) |=>
      alt_np_en[0] == $past(mgmt_wdata[phy_cfg_pkg::POS_ALT_NP])
      && fiber_mode[0] == $past(mgmt_wdata[phy_cfg_pkg::POS_FIBER]))
      else $error("Port configuration write not applied");
   a_crs_normal: assert property (
      !crs_sel_reg[1] |=> mii_crs[1] == $past(core_crs[1]))
      else $error("CRS not following carrier in normal mode");
   a_nibble_data: assert property (
      (!serial_reg[1] && core_dv[1]) |=> mii_rxd[1] == $past(core_rxd[1]))
      else $error("Nibble receive data wrong");
   a_line_track: assert property (
      !gain_hold[1] |=> line_len_reg[1] == $past(line_len_est[1]))
      else $error("Cable length not tracking estimate");
   a_rise_write: assert property (
      (wr_spc && mgmt_port) |=>
      rise_sel[1] == $past(mgmt_wdata[phy_cfg_pkg::POS_RISE +: 2]))
      else $error("Rise time write not applied");
   a_mdix_auto: assert property (
      auto_mdix_reg[0] |-> tx_on_pair_b[0] == auto_pair_swap[0])
      else $error("Automatic crossover not honoured");
   a_loop_write: assert property (
      (wr_spc && mgmt_port) |=>
      analog_loop_en[1] == $past(mgmt_wdata[phy_cfg_pkg::POS_ANA_LOOP]))
      else $error("Analog loopback write not applied");
   a_detect_write: assert property (
      (wr_spc && !mgmt_port) |=>
      loop_detect_run[0] == $past(mgmt_wdata[phy_cfg_pkg::POS_LD_EN]))
      else $error("Loopback detect enable write not applied");
   a_detect_fast: assert property (
      (wr_spc && mgmt_port) |=> loop_detect_fast[1]
      == $past(mgmt_wdata[phy_cfg_pkg::POS_LD_EN]
      && mgmt_wdata[phy_cfg_pkg::POS_LD_FAST]))
      else $error("Loopback speed-up not applied");
   a_found_clear: assert property (
      !loop_detect_run[0] |=> !ld_found_reg[0])
      else $error("Loopback status set while detection off");

   c_preamble_frame: cover property (
      pre_en_reg[0] && mii_rx_dv[0] ##1 !mii_rx_dv[0]);
   c_serial_frame: cover property (
      serial_reg[1] && ten_mbps[1] && mii_rx_dv[1]);
   c_crs_extend: cover property (
      !core_crs[0] && mii_crs[0] && crs_sel_reg[0]);
   c_loop_found: cover property (mgmt_rvalid && mgmt_rdata[4]);
   c_rise_write: cover property (wr_spc && mgmt_port);
endmodule
`default_nettype wire

// ==== testbench/rx_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module rx_core_model (
   // Clock and frame request.
   input wire logic clk,
   input wire logic go,
   // Receive core outputs.
   output logic crs,
   output logic dv,
   output logic [3:0] rxd,
   output logic rx_bit
);
   int t = 0;
   initial begin
      crs = 1'b0;
      dv = 1'b0;
      rxd = 4'h0;
      rx_bit = 1'b0;
   end
   // Carrier leads data by two cycles and drops two cycles before it.
   always @(negedge clk) begin
      rxd <= rxd + 4'h3;
      rx_bit <= ~rx_bit;
      if (go && t == 0) begin
         t <= 1;
      end else if (t != 0) begin
         t <= (t == 12) ? 0 : t + 1;
      end
      crs <= t >= 1 && t < 9;
      dv <= t >= 3 && t < 11;
   end
endmodule
`default_nettype wire

// ==== testbench/tb_phy_port_special_config_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_phy_port_special_config_regs;
   localparam logic [15:0] CFG_W = 16'h00af;
   localparam logic [15:0] SP_W = 16'h0fe0;
   logic clk, reset_n, mgmt_port, mgmt_wr_en, mgmt_rd_en;
   logic mgmt_rvalid, mgmt_ready, mon_on, mon_v;
   logic [1:0] media_select_strap, rise_time_strap, go;
   logic [4:0] mgmt_addr;
   logic [15:0] mgmt_wdata, mgmt_rdata, w, d;
   logic [1:0] ten_mbps, gain_hold, loop_seen, auto_pair_swap, fef_request;
   logic [1:0] fef_tx, alt_np_en, fiber_mode, tx_on_pair_b, analog_loop_en;
   logic [1:0] loop_detect_run, loop_detect_fast, core_crs, core_dv;
   logic [1:0] core_rx_bit, mii_crs, mii_rx_dv, e_crs, e_dv;
   logic [2:0] line_len_est [2];
   logic [2:0] ll_m [2];
   logic [1:0] rise_sel [2];
   logic [15:0] rise_time_ps [2];
   logic [15:0] cfg_m [2];
   logic [15:0] sp_m [2];
   logic [3:0] core_rxd [2];
   logic [3:0] mii_rxd [2];
   logic [3:0] e_rxd [2];
   int failures = 0;
   int check_count = 0;

   phy_port_special_config_regs dut (.clk(clk), .reset_n(reset_n),
      .media_select_strap(media_select_strap),
      .rise_time_strap(rise_time_strap), .mgmt_port(mgmt_port),
      .mgmt_addr(mgmt_addr), .mgmt_wr_en(mgmt_wr_en),
      .mgmt_rd_en(mgmt_rd_en), .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
      .mgmt_ready(mgmt_ready), .ten_mbps(ten_mbps), .gain_hold(gain_hold),
      .line_len_est(line_len_est), .loop_seen(loop_seen),
      .auto_pair_swap(auto_pair_swap), .fef_request(fef_request),
      .fef_tx(fef_tx), .alt_np_en(alt_np_en), .fiber_mode(fiber_mode),
      .rise_sel(rise_sel), .rise_time_ps(rise_time_ps),
      .tx_on_pair_b(tx_on_pair_b), .analog_loop_en(analog_loop_en),
      .loop_detect_run(loop_detect_run),
      .loop_detect_fast(loop_detect_fast), .core_crs(core_crs),
      .core_dv(core_dv), .core_rxd(core_rxd), .core_rx_bit(core_rx_bit),
      .mii_crs(mii_crs), .mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd));
   rx_core_model m0 (.clk(clk), .go(go[0]), .crs(core_crs[0]),
      .dv(core_dv[0]), .rxd(core_rxd[0]), .rx_bit(core_rx_bit[0]));
   rx_core_model m1 (.clk(clk), .go(go[1]), .crs(core_crs[1]),
      .dv(core_dv[1]), .rxd(core_rxd[1]), .rx_bit(core_rx_bit[1]));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic tally_and_finish;
      if (failures == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic reg_write(input int p, input logic [4:0] a,
                            input logic [15:0] v);
      @(negedge clk);
      mgmt_port = 1'(p);
      mgmt_addr = a;
      mgmt_wdata = v;
      mgmt_wr_en = 1'b1;
      @(negedge clk);
      mgmt_wr_en = 1'b0;
   endtask

   task automatic reg_read(input int p, input logic [4:0] a);
      int n;
      n = 0;
      @(negedge clk);
      mgmt_port = 1'(p);
      mgmt_addr = a;
      mgmt_rd_en = 1'b1;
      @(negedge clk);
      mgmt_rd_en = 1'b0;
      while (mgmt_rvalid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      check("rvalid", 16'(mgmt_rvalid), 16'h0001);
      d = mgmt_rdata;
   endtask

   function automatic logic [3:0] exp_rxd(int p);
      if (!(core_dv[p] | (cfg_m[p][5] & core_crs[p]))) begin
         return 4'h0;
      end
      if (cfg_m[p][3] & ten_mbps[p]) begin
         return {3'h0, core_rx_bit[p]};
      end
      return core_rxd[p];
   endfunction

   task automatic regs_chk(input int p);
      reg_read(p, phy_cfg_pkg::ADDR_PORT_CFG);
      check("port_configuration", d, cfg_m[p]);
      reg_read(p, phy_cfg_pkg::ADDR_SPECIAL);
      w = {ll_m[p], 1'b0, sp_m[p][11:5], loop_seen[p] & sp_m[p][6], 4'h0};
      check("special_function", d, w);
      w = 16'(fef_request[p] & cfg_m[p][2]);
      check("fef_tx", 16'(fef_tx[p]), w);
      check("alt_np_en", 16'(alt_np_en[p]), 16'(cfg_m[p][1]));
      check("fiber_mode", 16'(fiber_mode[p]), 16'(cfg_m[p][0]));
      check("rise_sel", 16'(rise_sel[p]), 16'(sp_m[p][11:10]));
      w = 16'(3300 + 300 * sp_m[p][11:10]);
      check("rise_ps", rise_time_ps[p], w);
      w = 16'(sp_m[p][9] ? auto_pair_swap[p] : sp_m[p][8]);
      check("tx_on_pair_b", 16'(tx_on_pair_b[p]), w);
      check("analog_loop", 16'(analog_loop_en[p]), 16'(sp_m[p][7]));
      check("ld_run", 16'(loop_detect_run[p]), 16'(sp_m[p][6]));
      w = 16'(sp_m[p][6] & sp_m[p][5]);
      check("ld_fast", 16'(loop_detect_fast[p]), w);
   endtask

   always @(posedge clk) begin
      mon_v <= mon_on;
      for (int p = 0; p < 2; p++) begin
         e_crs[p] <= core_crs[p] | (cfg_m[p][7] & ten_mbps[p] & core_dv[p]);
         e_dv[p] <= core_dv[p] | (cfg_m[p][5] & core_crs[p]);
         e_rxd[p] <= exp_rxd(p);
      end
   end

   always @(negedge clk) begin
      if (mon_v) begin
         for (int p = 0; p < 2; p++) begin
            check("mii_crs", 16'(mii_crs[p]), 16'(e_crs[p]));
            check("mii_rx_dv", 16'(mii_rx_dv[p]), 16'(e_dv[p]));
            check("mii_rxd", 16'(mii_rxd[p]), 16'(e_rxd[p]));
         end
      end
   end

   initial begin
      #(100 * 20000);
      failures++;
      tally_and_finish();
   end

   initial begin
      void'($urandom(97));
      reset_n = 1'b0;
      {mgmt_port, mgmt_wr_en, mgmt_rd_en, mon_on, mon_v} = 5'h00;
      mgmt_addr = 5'h00;
      mgmt_wdata = 16'h0000;
      {ten_mbps, gain_hold, loop_seen, auto_pair_swap} = 8'h00;
      fef_request = 2'h0;
      go = 2'h0;
      line_len_est = '{3'h0, 3'h0};
      ll_m = '{3'h0, 3'h0};
      media_select_strap = 2'($urandom);
      rise_time_strap = 2'($urandom);
      repeat (6) @(negedge clk);
      reset_n = 1'b1;
      for (int n = 0; n < 20 && mgmt_ready !== 1'b1; n++) begin
         @(negedge clk);
      end
      check("mgmt_ready", 16'(mgmt_ready), 16'h0001);
      for (int p = 0; p < 2; p++) begin
         cfg_m[p] = 16'h0084 | 16'(media_select_strap[p]);
         sp_m[p] = 16'h0300 | {4'h0, rise_time_strap, 10'h000};
         regs_chk(p);
      end
      cfg_m[0] = cfg_m[0] ^ 16'h0001;
      @(negedge clk);
      mgmt_port = 1'b0;
      mgmt_addr = phy_cfg_pkg::ADDR_PORT_CFG;
      mgmt_wdata = cfg_m[0];
      mgmt_wr_en = 1'b1;
      @(negedge clk);
      mgmt_wr_en = 1'b0;
      mgmt_rd_en = 1'b1;
      @(negedge clk);
      mgmt_rd_en = 1'b0;
      check("read_after_write", mgmt_rdata, cfg_m[0]);
      check("fiber_after_write", 16'(fiber_mode[0]), 16'(cfg_m[0][0]));
      for (int r = 0; r < 8; r++) begin
         for (int p = 0; p < 2; p++) begin
            w = (r == 0) ? 16'hffff : (r == 1) ? 16'h0000 : 16'($urandom);
            cfg_m[p] = w & CFG_W;
            reg_write(p, phy_cfg_pkg::ADDR_PORT_CFG, cfg_m[p]);
            w = 16'($urandom);
            w[11:10] = 2'(r + p);
            sp_m[p] = w & SP_W;
            reg_write(p, phy_cfg_pkg::ADDR_SPECIAL, sp_m[p]);
            reg_write(p, 5'h11, 16'($urandom));
            reg_read(p, 5'h11);
            check("unmapped", d, 16'h0000);
         end
         {ten_mbps, gain_hold, loop_seen, auto_pair_swap} = 8'($urandom);
         fef_request = 2'($urandom);
         for (int p = 0; p < 2; p++) begin
            line_len_est[p] = 3'($urandom);
            ll_m[p] = gain_hold[p] ? ll_m[p] : line_len_est[p];
         end
         mon_on = 1'b1;
         go <= 2'h3;
         @(negedge clk);
         go <= 2'h0;
         repeat (15) @(negedge clk);
         mon_on = 1'b0;
         for (int p = 0; p < 2; p++) begin
            regs_chk(p);
         end
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
